// [hw/edge_irq.sv]
// pin edge detection with sticky status, write-one-to-clear and mask
`default_nettype none
module edge_irq #(
	parameter int N = 2
) (
	input  wire logic         i_clk,
	input  wire logic         i_sys_rst,
	input  wire logic         i_clk_en,
	input  wire logic [N-1:0] i_pin,
	input  wire logic [N-1:0] i_enable,
	input  wire logic [N-1:0] i_clear,
	input  wire logic [N-1:0] i_mask,
	output logic      [N-1:0] o_status,
	output logic              o_irq
);
	logic [N-1:0] prev_r;
	logic [N-1:0] status_r;
	logic [N-1:0] status_nxt;
	logic [N-1:0] event_w;

	// falling edge only; disabled pins never reach the status bit
	assign event_w    = prev_r & ~i_pin & i_enable;
	// a new event beats a clear in the same cycle
	assign status_nxt = (status_r & ~i_clear) | event_w;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			prev_r   <= '1;
			status_r <= '0;
		end else if (i_clk_en) begin
			prev_r   <= i_pin;
			status_r <= status_nxt;
		end
	end

	assign o_status = status_r;
	assign o_irq    = |(status_r & i_mask);
endmodule
`default_nettype wire

// [hw/gpio_pin_params.svh]
// offsets, field positions and reset values of the port b/c pin configuration block
`ifndef GPIO_PIN_PARAMS_SVH
`define GPIO_PIN_PARAMS_SVH

`define GPC_OFF_PB_DATA     8'hF1
`define GPC_OFF_PC_DATA     8'hF2
`define GPC_OFF_PB_MODE     8'hF3
`define GPC_OFF_PB_PULLUP   8'hF4
`define GPC_OFF_PC_MODE     8'hF5
`define GPC_OFF_PC_IRQ_EN   8'hF6
`define GPC_OFF_IRQ_STATUS  8'hF7
`define GPC_OFF_IRQ_MASK    8'hF8

`define GPC_RST_PB_MODE     8'h00
`define GPC_RST_PB_PULLUP   4'h0
`define GPC_RST_PC_MODE     4'h0
`define GPC_RST_PC_IRQ_EN   2'h0
`define GPC_RST_PB_DATA     4'h0
`define GPC_RST_PC_DATA     2'h0
`define GPC_RST_IRQ_MASK    2'h0

`define GPC_PB_SCK_PIN      0
`define GPC_PB_SO_PIN       1
`define GPC_PB_SI_PIN       2
`define GPC_PB_ALT_MASK     4'h3
`define GPC_PC_ALT_MASK     2'h0

`endif

// [hw/gpio_pin_pkg.sv]
// types and pin mode decoding shared by the port b/c pin configuration block
`default_nettype none
package gpio_pin_pkg;

	typedef enum logic [1:0] {
		MODE_INPUT      = 2'h0,
		MODE_PUSH_PULL  = 2'h1,
		MODE_OPEN_DRAIN = 2'h2,
		MODE_ALT_OUT    = 2'h3
	} pin_mode_e;

	typedef struct packed {
		logic drive;
		logic level;
	} pin_drive_s;

	// 2-bit mode to pad drive; alt code only counts where the pin has a serial output
	function automatic pin_drive_s pin_decode(input logic [1:0] mode, input logic data,
		input logic alt_ok, input logic alt_level);
		pin_drive_s d;
		d = '{drive: 1'b0, level: 1'b1};
		if (mode == MODE_PUSH_PULL) begin
			d = '{drive: 1'b1, level: data};
		end else if (mode == MODE_OPEN_DRAIN) begin
			d = '{drive: ~data, level: 1'b0};
		end else if (mode == MODE_ALT_OUT && alt_ok) begin
			d = '{drive: 1'b1, level: alt_level};
		end
		return d;
	endfunction

	function automatic logic is_input(input logic [1:0] mode, input logic alt_ok);
		return (mode == MODE_INPUT) || (mode == MODE_ALT_OUT && !alt_ok);
	endfunction

endpackage
`default_nettype wire

// [hw/pin_bank.sv]
// bank of pins turning 2-bit mode fields into registered pad drive
`default_nettype none
module pin_bank
	import gpio_pin_pkg::*;
#(
	parameter int             N        = 4,
	parameter logic [N-1:0]   ALT_MASK = '0
) (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_clk_en,
	pin_bank_if.bank  pins
);
	logic [N-1:0] out_nxt;
	logic [N-1:0] oe_n_nxt;
	logic [N-1:0] out_r;
	logic [N-1:0] oe_n_r;

	always_comb begin
		for (int i = 0; i < N; i++) begin
			pin_drive_s d;
			d = pin_decode(pins.mode[2*i +: 2], pins.level[i], ALT_MASK[i], pins.alt_level[i]);
			out_nxt[i]  = d.level;
			oe_n_nxt[i] = ~d.drive;
		end
	end

	// pads come up released so nothing fights the board before software decides
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			out_r  <= '1;
			oe_n_r <= '1;
		end else if (i_clk_en) begin
			out_r  <= out_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	assign pins.pad_out  = out_r;
	assign pins.pad_oe_n = oe_n_r;
endmodule
`default_nettype wire

// [hw/pin_bank_if.sv]
// carrier between the register side and a bank of configurable pins
`default_nettype none
interface pin_bank_if #(parameter int N = 4);
	logic [2*N-1:0] mode;
	logic [N-1:0]   level;
	logic [N-1:0]   alt_level;
	logic [N-1:0]   pad_out;
	logic [N-1:0]   pad_oe_n;

	modport ctl  (output mode, output level, output alt_level, input pad_out, input pad_oe_n);
	modport bank (input mode, input level, input alt_level, output pad_out, output pad_oe_n);
endinterface
`default_nettype wire

// [hw/port_b_c_pin_config.sv]
// pin configuration for the four-pin port b and the two-pin port c
//
// The strobed register port was chosen for this implementation.
`include "gpio_pin_params.svh"
`default_nettype none

// Notes on behaviour
// - serial-clock pin in mode 0,0 is an input feeding the serial engine clock.
// - each port c pin has an enable; 0 blocks its interrupts, 1 allows them.
// - port c interrupt enable keeps two read/write bits, both zero after reset.
// - port c mode register holds fields at bits 3:2 and 1:0; 1,1 unavailable.
// - bits 7 to 2 of port c interrupt enable are unimplemented, writes ignored.
module port_b_c_pin_config
	import gpio_pin_pkg::*;
#(
	parameter int PB_PINS = 4,
	parameter int PC_PINS = 2
) (
	input  wire logic               i_clk,
	input  wire logic               i_sys_rst,
	input  wire logic               i_clk_en,
	input  wire logic [7:0]         i_addr,
	input  wire logic [7:0]         i_wr_data,
	input  wire logic               i_wr_stb,
	input  wire logic               i_rd_stb,
	output logic      [7:0]         o_rd_data,
	input  wire logic [PB_PINS-1:0] i_pb_pin,
	output logic      [PB_PINS-1:0] o_pb_pin,
	output logic      [PB_PINS-1:0] o_pb_pin_oe_n,
	output logic      [PB_PINS-1:0] o_pb_pullup_en,
	input  wire logic [PC_PINS-1:0] i_pc_pin,
	output logic      [PC_PINS-1:0] o_pc_pin,
	output logic      [PC_PINS-1:0] o_pc_pin_oe_n,
	input  wire logic               i_ser_clk_out,
	input  wire logic               i_ser_data_out,
	output logic                    o_ser_clk_in,
	output logic                    o_ser_data_in,
	output logic                    o_external_irq_pin,
	output logic                    o_irq
);

	// register storage
	logic [7:0]         pb_mode_r;
	logic [PB_PINS-1:0] pb_pullup_r;
	logic [3:0]         pc_mode_r;
	logic [PC_PINS-1:0] pc_irq_en_r;
	logic [PB_PINS-1:0] pb_data_r;
	logic [PC_PINS-1:0] pc_data_r;
	logic [PC_PINS-1:0] irq_mask_r;
	logic [7:0]         rd_data_r;
	logic               ser_clk_in_r;
	logic               ser_data_in_r;

	// address decode
	logic hit_pb_data;
	logic hit_pc_data;
	logic hit_pb_mode;
	logic hit_pb_pullup;
	logic hit_pc_mode;
	logic hit_pc_irq_en;
	logic hit_irq_status;
	logic hit_irq_mask;
	logic hit_any;

	logic               wr_go;
	logic               rd_go;
	logic [7:0]         rd_data_nxt;
	logic [PC_PINS-1:0] irq_status;
	logic [PC_PINS-1:0] irq_clear;
	logic               pc_irq_line;

	assign hit_pb_data    = (i_addr == `GPC_OFF_PB_DATA);
	assign hit_pc_data    = (i_addr == `GPC_OFF_PC_DATA);
	assign hit_pb_mode    = (i_addr == `GPC_OFF_PB_MODE);
	assign hit_pb_pullup  = (i_addr == `GPC_OFF_PB_PULLUP);
	assign hit_pc_mode    = (i_addr == `GPC_OFF_PC_MODE);
	assign hit_pc_irq_en  = (i_addr == `GPC_OFF_PC_IRQ_EN);
	assign hit_irq_status = (i_addr == `GPC_OFF_IRQ_STATUS);
	assign hit_irq_mask   = (i_addr == `GPC_OFF_IRQ_MASK);
	assign hit_any        = hit_pb_data | hit_pc_data | hit_pb_mode | hit_pb_pullup |
	                        hit_pc_mode | hit_pc_irq_en | hit_irq_status | hit_irq_mask;

	assign wr_go = i_wr_stb & i_clk_en;
	assign rd_go = i_rd_stb & i_clk_en;

	// write-one-to-clear of the sticky status bits
	assign irq_clear = (wr_go && hit_irq_status) ? i_wr_data[PC_PINS-1:0] : '0;

	// register writes; unmapped writes are dropped silently
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pb_mode_r   <= `GPC_RST_PB_MODE;
			pb_pullup_r <= `GPC_RST_PB_PULLUP;
			pc_mode_r   <= `GPC_RST_PC_MODE;
			pc_irq_en_r <= `GPC_RST_PC_IRQ_EN;
			pb_data_r   <= `GPC_RST_PB_DATA;
			pc_data_r   <= `GPC_RST_PC_DATA;
			irq_mask_r  <= `GPC_RST_IRQ_MASK;
		end else if (wr_go) begin
			if (hit_pb_mode) begin
				pb_mode_r <= i_wr_data;
			end else if (hit_pb_pullup) begin
				pb_pullup_r <= i_wr_data[PB_PINS-1:0];
			end else if (hit_pc_mode) begin
				pc_mode_r <= i_wr_data[3:0];
			end else if (hit_pc_irq_en) begin
				// upper bits have no storage
				pc_irq_en_r <= i_wr_data[PC_PINS-1:0];
			end else if (hit_pb_data) begin
				pb_data_r <= i_wr_data[PB_PINS-1:0];
			end else if (hit_pc_data) begin
				pc_data_r <= i_wr_data[PC_PINS-1:0];
			end else if (hit_irq_mask) begin
				irq_mask_r <= i_wr_data[PC_PINS-1:0];
			end
		end
	end

	// read decode; data registers read back the pin levels, not the latch
	always_comb begin
		rd_data_nxt = 8'h00;
		if (!hit_any) begin
			rd_data_nxt = 8'h00;
		end else if (hit_pb_mode) begin
			rd_data_nxt = pb_mode_r;
		end else if (hit_pb_pullup) begin
			rd_data_nxt = {{(8-PB_PINS){1'b0}}, pb_pullup_r};
		end else if (hit_pc_mode) begin
			rd_data_nxt = {4'h0, pc_mode_r};
		end else if (hit_pc_irq_en) begin
			rd_data_nxt = {{(8-PC_PINS){1'b0}}, pc_irq_en_r};
		end else if (hit_pb_data) begin
			rd_data_nxt = {{(8-PB_PINS){1'b0}}, i_pb_pin};
		end else if (hit_pc_data) begin
			rd_data_nxt = {{(8-PC_PINS){1'b0}}, i_pc_pin};
		end else if (hit_irq_status) begin
			rd_data_nxt = {{(8-PC_PINS){1'b0}}, irq_status};
		end else if (hit_irq_mask) begin
			rd_data_nxt = {{(8-PC_PINS){1'b0}}, irq_mask_r};
		end
	end

	// read data stand one enabled cycle only, zero otherwise; held while the clock enable is low
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rd_data_r <= 8'h00;
		end else if (i_clk_en) begin
			rd_data_r <= rd_go ? rd_data_nxt : 8'h00;
		end
	end

	assign o_rd_data = rd_data_r;

	// port b pads
	pin_bank_if #(.N(PB_PINS)) pb_if ();

	assign pb_if.mode = pb_mode_r;
	assign pb_if.level = pb_data_r;

	always_comb begin
		pb_if.alt_level = pb_data_r;
		pb_if.alt_level[`GPC_PB_SCK_PIN] = i_ser_clk_out;
		pb_if.alt_level[`GPC_PB_SO_PIN]  = i_ser_data_out;
	end

	pin_bank #(
		.N        (PB_PINS),
		.ALT_MASK (PB_PINS'(`GPC_PB_ALT_MASK))
	) u_pb_bank (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_clk_en  (i_clk_en),
		.pins      (pb_if.bank)
	);

	assign o_pb_pin       = pb_if.pad_out;
	assign o_pb_pin_oe_n  = pb_if.pad_oe_n;
	assign o_pb_pullup_en = pb_pullup_r;

	// port c pads; no serial function, so code 1,1 stays an input
	pin_bank_if #(.N(PC_PINS)) pc_if ();

	assign pc_if.mode      = pc_mode_r;
	assign pc_if.level     = pc_data_r;
	assign pc_if.alt_level = pc_data_r;

	pin_bank #(
		.N        (PC_PINS),
		.ALT_MASK (PC_PINS'(`GPC_PC_ALT_MASK))
	) u_pc_bank (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_clk_en  (i_clk_en),
		.pins      (pc_if.bank)
	);

	assign o_pc_pin      = pc_if.pad_out;
	assign o_pc_pin_oe_n = pc_if.pad_oe_n;

	// serial engine inputs; held high when the pin is not an input so the
	// engine sees an idle line rather than our own drive
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ser_clk_in_r  <= 1'b1;
			ser_data_in_r <= 1'b1;
		end else if (i_clk_en) begin
			ser_clk_in_r <= (pb_mode_r[2*`GPC_PB_SCK_PIN +: 2] == MODE_INPUT) ?
			                i_pb_pin[`GPC_PB_SCK_PIN] : 1'b1;
			ser_data_in_r <= is_input(pb_mode_r[2*`GPC_PB_SI_PIN +: 2], 1'b0) ?
			                 i_pb_pin[`GPC_PB_SI_PIN] : 1'b1;
		end
	end

	assign o_ser_clk_in  = ser_clk_in_r;
	assign o_ser_data_in = ser_data_in_r;

	// port c pin interrupts
	edge_irq #(
		.N (PC_PINS)
	) u_pc_irq (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_clk_en  (i_clk_en),
		.i_pin     (i_pc_pin),
		.i_enable  (pc_irq_en_r),
		.i_clear   (irq_clear),
		.i_mask    (irq_mask_r),
		.o_status  (irq_status),
		.o_irq     (pc_irq_line)
	);

	assign o_irq              = pc_irq_line;
	assign o_external_irq_pin = irq_status[0];

endmodule
`default_nettype wire

// [verification/board_pins.sv]
// board side of the pads: external drivers, pull-ups and floating lines
`default_nettype none
module board_pins #(
	parameter int N = 4
) (
	input  wire logic         i_clk,
	input  wire logic [N-1:0] i_out,
	input  wire logic [N-1:0] i_oe_n,
	input  wire logic [N-1:0] i_pull,
	input  wire logic [N-1:0] i_ext_lvl,
	input  wire logic [N-1:0] i_ext_en,
	output logic      [N-1:0] o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [N-1:0] flt_r = '0;
	// a line nobody drives toggles, so a stale level never reads as good
	always @(posedge i_clk) flt_r <= ~flt_r;
	always_comb begin
		for (int k = 0; k < N; k++) begin
			if (!i_oe_n[k]) o_pin[k] = i_out[k];
			else if (i_ext_en[k]) o_pin[k] = i_ext_lvl[k];
			else if (i_pull[k]) o_pin[k] = 1'b1;
			else o_pin[k] = flt_r[k];
		end
	end
endmodule
`default_nettype wire

// [verification/pin_config_sva.sv]
// assertions on the ports of the port b/c pin configuration block
`default_nettype none
module pin_config_sva #(
	parameter int PB_PINS = 4,
	parameter int PC_PINS = 2
) (
	input wire logic               i_clk,
	input wire logic               i_sys_rst,
	input wire logic               i_clk_en,
	input wire logic [7:0]         i_addr,
	input wire logic [7:0]         i_wr_data,
	input wire logic               i_wr_stb,
	input wire logic               i_rd_stb,
	input wire logic [7:0]         o_rd_data,
	input wire logic [PB_PINS-1:0] i_pb_pin,
	input wire logic [PB_PINS-1:0] o_pb_pin,
	input wire logic [PB_PINS-1:0] o_pb_pin_oe_n,
	input wire logic [PC_PINS-1:0] i_pc_pin,
	input wire logic [PC_PINS-1:0] o_pc_pin_oe_n,
	input wire logic               i_ser_clk_out,
	input wire logic               o_ser_clk_in,
	input wire logic               o_external_irq_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] pbm_r;
	logic [3:0] pbd_r;
	logic [3:0] pcm_r;
	logic [1:0] pce_r;
	wire logic  we = i_wr_stb && i_clk_en;
	// shadow copies of the port b mode and data, port c mode and port c interrupt enable registers
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pbm_r <= 8'h00;
			pbd_r <= 4'h0;
			pcm_r <= 4'h0;
			pce_r <= 2'h0;
		end else if (we) begin
			if (i_addr == 8'hF3) pbm_r <= i_wr_data;
			if (i_addr == 8'hF1) pbd_r <= i_wr_data[3:0];
			if (i_addr == 8'hF5) pcm_r <= i_wr_data[3:0];
			if (i_addr == 8'hF6) pce_r <= i_wr_data[1:0];
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	property p_sck_in; $past(pbm_r[1:0]) == 2'h0 && !$past(i_sys_rst) |-> o_ser_clk_in == $past(i_pb_pin[0]); endproperty
	a_sck_in: assert property (p_sck_in) else $error("serial clock input wrong");
	property p_irq_blk; !pce_r[0] && !o_external_irq_pin |=> !o_external_irq_pin; endproperty
	a_irq_blk: assert property (p_irq_blk) else $error("disabled pin raised event");
	property p_irq_set; pce_r[0] && $past(i_pc_pin[0]) && !i_pc_pin[0] |=> o_external_irq_pin; endproperty
	a_irq_set: assert property (p_irq_set) else $error("enabled fall not seen");
	property p_ien_rd; i_rd_stb && i_addr == 8'hF6 |=> o_rd_data == {6'h00, $past(pce_r)}; endproperty
	a_ien_rd: assert property (p_ien_rd) else $error("irq enable read wrong");
	property p_pcm_rd; i_rd_stb && i_addr == 8'hF5 |=> o_rd_data == {4'h0, $past(pcm_r)}; endproperty
	a_pcm_rd: assert property (p_pcm_rd) else $error("port c mode read wrong");
	property p_pc_na; $past(pcm_r[1:0]) == 2'h3 |-> o_pc_pin_oe_n[0]; endproperty
	a_pc_na: assert property (p_pc_na) else $error("port c code 3 drives");
	property p_pp; $past(pbm_r[3:2]) == 2'h1 |-> !o_pb_pin_oe_n[1] && o_pb_pin[1] == $past(pbd_r[1]); endproperty
	a_pp: assert property (p_pp) else $error("push-pull pin wrong");
	property p_od; $past(pbm_r[7:6]) == 2'h2 |-> o_pb_pin_oe_n[3] == $past(pbd_r[3]) && !o_pb_pin[3]; endproperty
	a_od: assert property (p_od) else $error("open-drain pin wrong");
	property p_alt; $past(pbm_r[1:0]) == 2'h3 |-> !o_pb_pin_oe_n[0] && o_pb_pin[0] == $past(i_ser_clk_out); endproperty
	a_alt: assert property (p_alt) else $error("serial clock out wrong");
	property p_na; $past(pbm_r[5:4]) == 2'h3 |-> o_pb_pin_oe_n[2]; endproperty
	a_na: assert property (p_na) else $error("pin 2 code 3 drives");
	c_mode: cover property (we && i_addr == 8'hF3);
	c_irq: cover property ($rose(o_external_irq_pin));
	c_ien: cover property (i_rd_stb && i_addr == 8'hF6);
endmodule
bind port_b_c_pin_config pin_config_sva #(.PB_PINS(PB_PINS), .PC_PINS(PC_PINS)) pin_config_sva_i (
	.i_clk, .i_sys_rst, .i_clk_en, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb, .o_rd_data, .i_pb_pin,
	.o_pb_pin, .o_pb_pin_oe_n, .i_pc_pin, .o_pc_pin_oe_n, .i_ser_clk_out, .o_ser_clk_in, .o_external_irq_pin);
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the port b/c pin configuration block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       i_clk = 1'b0;
	logic       i_sys_rst = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wr_data = 8'h00;
	logic       i_wr_stb = 1'b0;
	logic       i_rd_stb = 1'b0;
	logic       clk_en = 1'b1;
	logic       sck_o = 1'b0;
	logic       sdo_o = 1'b1;
	logic [3:0] pb_lvl = 4'h0;
	logic [1:0] pc_lvl = 2'h3;
	wire logic [7:0] o_rd_data;
	wire logic [3:0] pb_in, pb_out, pb_oe_n, pb_pull;
	wire logic [1:0] pc_in, pc_out, pc_oe_n;
	wire logic       sck_i, sdi_i, ext_irq, o_irq;
	int n_fail = 0;
	int check_count = 0;
	logic [3:0] pb_oe [4] = '{4'hF, 4'h0, 4'hF, 4'hC};
	logic [3:0] pb_dr [4] = '{4'h0, 4'hF, 4'h0, 4'h2};
	logic [1:0] pc_oe [4] = '{2'h3, 2'h0, 2'h3, 2'h3};
	always #12.5 i_clk = ~i_clk;
	port_b_c_pin_config port_b_c_pin_config_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(clk_en),
		.i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
		.i_pb_pin(pb_in), .o_pb_pin(pb_out), .o_pb_pin_oe_n(pb_oe_n), .o_pb_pullup_en(pb_pull),
		.i_pc_pin(pc_in), .o_pc_pin(pc_out), .o_pc_pin_oe_n(pc_oe_n), .i_ser_clk_out(sck_o),
		.i_ser_data_out(sdo_o), .o_ser_clk_in(sck_i), .o_ser_data_in(sdi_i), .o_external_irq_pin(ext_irq),
		.o_irq(o_irq));
	board_pins #(.N(4)) board_pins_i (.i_clk(i_clk), .i_out(pb_out), .i_oe_n(pb_oe_n), .i_pull(pb_pull),
		.i_ext_lvl(pb_lvl), .i_ext_en(4'hF), .o_pin(pb_in));
	board_pins #(.N(2)) board_pins_c_i (.i_clk(i_clk), .i_out(pc_out), .i_oe_n(pc_oe_n), .i_pull(2'h0),
		.i_ext_lvl(pc_lvl), .i_ext_en(2'h3), .o_pin(pc_in));
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wr_data <= d;
		i_wr_stb <= 1'b1;
		@(posedge i_clk);
		i_wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_addr <= a;
		i_rd_stb <= 1'b1;
		@(posedge i_clk);
		i_rd_stb <= 1'b0;
		#1 chk($sformatf("reg %h", a), exp, o_rd_data);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		rd(8'hF3, 8'h00);
		rd(8'hF5, 8'h00);
		rd(8'hF6, 8'h00);
		wr(8'hF6, 8'hFF);
		rd(8'hF6, 8'h03);
		wr(8'hF5, 8'hFE);
		rd(8'hF5, 8'h0E);
		wr(8'hF0, 8'hFF);
		rd(8'hF0, 8'h00);
		wr(8'hF4, 8'hFA);
		rd(8'hF4, 8'h0A);
		chk("pullup", 8'h0A, {4'h0, pb_pull});
		$display("test registers done");
		wr(8'hF1, 8'h0F);
		wr(8'hF2, 8'h03);
		for (int m = 0; m < 4; m++) begin
			wr(8'hF3, {4{m[1:0]}});
			wr(8'hF5, {4'h0, {2{m[1:0]}}});
			tick(2);
			chk("pb oe_n", {4'h0, pb_oe[m]}, {4'h0, pb_oe_n});
			chk("pb drive", {4'h0, pb_dr[m]}, {4'h0, pb_out & ~pb_oe_n});
			chk("pc oe_n", {6'h00, pc_oe[m]}, {6'h00, pc_oe_n});
			chk("pc drive", {6'h00, (m == 1) ? 2'h3 : 2'h0}, {6'h00, pc_out & ~pc_oe_n});
			chk("sck in", {7'h00, m != 0}, {7'h00, sck_i});
			chk("si in", {7'h00, m == 1 || m == 2}, {7'h00, sdi_i});
		end
		$display("test modes done");
		wr(8'hF3, 8'hB7);
		wr(8'hF1, 8'h02);
		sck_o <= 1'b1;
		tick(2);
		chk("mixed oe_n", 8'h04, {4'h0, pb_oe_n});
		chk("mixed drive", 8'h03, {4'h0, pb_out & ~pb_oe_n});
		wr(8'hF1, 8'h08);
		tick(2);
		chk("mixed oe_n", 8'h0C, {4'h0, pb_oe_n});
		chk("mixed drive", 8'h01, {4'h0, pb_out & ~pb_oe_n});
		$display("test pads done");
		wr(8'hF5, 8'h00);
		wr(8'hF6, 8'h01);
		wr(8'hF8, 8'h01);
		pc_lvl <= 2'h2;
		tick(3);
		chk("irq pin", 8'h01, {7'h00, ext_irq});
		chk("irq", 8'h01, {7'h00, o_irq});
		rd(8'hF7, 8'h01);
		wr(8'hF7, 8'h01);
		rd(8'hF7, 8'h00);
		chk("irq", 8'h00, {7'h00, o_irq});
		pc_lvl <= 2'h0;
		tick(3);
		rd(8'hF7, 8'h00);
		pc_lvl <= 2'h3;
		wr(8'hF6, 8'h03);
		wr(8'hF8, 8'h00);
		pc_lvl <= 2'h1;
		tick(3);
		rd(8'hF7, 8'h02);
		chk("irq masked", 8'h00, {7'h00, o_irq});
		wr(8'hF8, 8'h02);
		tick(1);
		chk("irq", 8'h01, {7'h00, o_irq});
		wr(8'hF7, 8'h03);
		tick(1);
		chk("irq", 8'h00, {7'h00, o_irq});
		$display("test interrupts done");
		// a write while the enable is low must leave the mask untouched
		clk_en <= 1'b0;
		wr(8'hF8, 8'h03);
		clk_en <= 1'b1;
		rd(8'hF8, 8'h02);
		chk("irq frozen", 8'h00, {7'h00, o_irq});
		// reset in mid-run returns the mask, port c interrupt enable and port c mode registers to zero
		@(posedge i_clk);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		rd(8'hF8, 8'h00);
		rd(8'hF6, 8'h00);
		rd(8'hF5, 8'h00);
		chk("irq after reset", 8'h00, {7'h00, o_irq});
		$display("test freeze and reset done");
		conclude();
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		n_fail++;
		conclude();
	end
endmodule
`default_nettype wire
